//--- src/hsm_lane_mux.sv
// High-speed lane multiplexer between peripheral controllers and four lanes
`timescale 1ns/1ps
module hsm_lane_mux (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Lane selection from configuration
  input wire hsm_pkg::hsm_sel_e [hsm_pkg::HSM_NUM_LANES-1:0] lane_sel,
  output hsm_pkg::hsm_sel_e [hsm_pkg::HSM_NUM_LANES-1:0] lane_route,
  // Transceiver lanes
  input wire hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_LANES-1:0] lane_rx,
  output hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_LANES-1:0] lane_tx,
  // PCI Express lanes
  input wire hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_LANES-1:0] pcie_tx,
  output hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_LANES-1:0] pcie_rx,
  // Storage channels a and b
  input wire hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_STORAGE-1:0] storage_tx,
  output hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_STORAGE-1:0] storage_rx,
  // Display lanes a and b, transmit only
  input wire hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_DISPLAY-1:0] display_tx,
  // USB controllers a and b
  input wire hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_USB-1:0] usb_tx,
  output hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_USB-1:0] usb_rx,
  // SGMII ports
  input wire hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_LANES-1:0] sgmii_tx,
  output hsm_pkg::hsm_word_s [hsm_pkg::HSM_NUM_LANES-1:0] sgmii_rx
);
  import hsm_pkg::*;

  hsm_state_s state_reg;
  hsm_state_s state_next;
  hsm_word_s [HSM_NUM_LANES-1:0] lane_tx_next;

  // Grant routes: a shared peripheral asked on two lanes goes to the lower lane
  always_comb begin
    logic [HSM_NUM_STORAGE-1:0] storage_used;
    logic [HSM_NUM_DISPLAY-1:0] display_used;
    logic usb_a_used;
    hsm_sel_e grant;
    storage_used = '0;
    display_used = '0;
    usb_a_used = 1'b0;
    grant = HSM_SEL_IDLE;
    state_next = state_reg;
    state_next.pcie_rx = '0;
    state_next.storage_rx = '0;
    state_next.usb_rx = '0;
    state_next.sgmii_rx = '0;
    for (int l = 0; l < HSM_NUM_LANES; l++) begin
      grant = HSM_SEL_IDLE;
      case (lane_sel[l])
        HSM_SEL_PCIE: begin
          grant = HSM_SEL_PCIE;
          state_next.pcie_rx[l] = lane_rx[l];
        end
        HSM_SEL_STORAGE: begin
          if (!storage_used[l[0]]) begin
            grant = HSM_SEL_STORAGE;
            storage_used[l[0]] = 1'b1;
            state_next.storage_rx[l[0]] = lane_rx[l];
          end
        end
        HSM_SEL_DISPLAY: begin
          // Even lanes carry display b, odd lanes display a
          if (!display_used[!l[0]]) begin
            grant = HSM_SEL_DISPLAY;
            display_used[!l[0]] = 1'b1;
          end
        end
        HSM_SEL_USB: begin
          if (l == HSM_USB_B_LANE) begin
            grant = HSM_SEL_USB;
            state_next.usb_rx[1] = lane_rx[l];
          end else if (!usb_a_used) begin
            grant = HSM_SEL_USB;
            usb_a_used = 1'b1;
            state_next.usb_rx[0] = lane_rx[l];
          end
        end
        HSM_SEL_SGMII: begin
          grant = HSM_SEL_SGMII;
          state_next.sgmii_rx[l] = lane_rx[l];
        end
        default: grant = HSM_SEL_IDLE;
      endcase
      state_next.route[l] = grant;
    end
    state_next.lane_tx = lane_tx_next;
  end

  // Transmit side follows the granted route of the same cycle
  for (genvar g = 0; g < HSM_NUM_LANES; g++) begin : g_lane
    hsm_lane_sel u_sel (
      .route(state_next.route[g]),
      .pcie_tx(pcie_tx[g]),
      .storage_tx(storage_tx[g % HSM_NUM_STORAGE]),
      .display_tx(display_tx[(g + 1) % HSM_NUM_DISPLAY]),
      .usb_tx(usb_tx[(g == HSM_USB_B_LANE) ? 1 : 0]),
      .sgmii_tx(sgmii_tx[g]),
      .lane_tx(lane_tx_next[g])
    );
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= HSM_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every data output is a flip-flop; one cycle from selection to lane
  assign lane_route = state_reg.route;
  assign lane_tx = state_reg.lane_tx;
  assign pcie_rx = state_reg.pcie_rx;
  assign storage_rx = state_reg.storage_rx;
  assign usb_rx = state_reg.usb_rx;
  assign sgmii_rx = state_reg.sgmii_rx;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Lane 0 is never the loser of a conflict, so only unknown codes idle it
  AST_LANE0_FOLLOWS_SEL: assert property (
    !$past(rst) |-> lane_route[0] == (($past(lane_sel[0]) > HSM_SEL_SGMII) ? HSM_SEL_IDLE : $past(lane_sel[0])))
    else $error("Lane 0 route does not follow its selection");

  AST_PCIE_TX_SAME_LANE: assert property (
    lane_route[1] == HSM_SEL_PCIE |-> lane_tx[1] == $past(pcie_tx[1]))
    else $error("PCIe lane 1 word not on transceiver lane 1");

  AST_PCIE_RX_LANE3: assert property (
    lane_route[3] == HSM_SEL_PCIE |-> pcie_rx[3] == $past(lane_rx[3]))
    else $error("Lane 3 receive word not delivered to PCIe lane 3");

  AST_STORAGE_B_LANE3: assert property (
    lane_route[3] == HSM_SEL_STORAGE && lane_route[1] != HSM_SEL_STORAGE
      |-> storage_rx[1] == $past(lane_rx[3]))
    else $error("Storage channel b not fed from lane 3");

  AST_STORAGE_A_ONCE: assert property (
    !(lane_route[0] == HSM_SEL_STORAGE && lane_route[2] == HSM_SEL_STORAGE))
    else $error("Storage channel a granted on two lanes");

  AST_DISPLAY_B_LANE2: assert property (
    lane_route[2] == HSM_SEL_DISPLAY |-> lane_tx[2] == $past(display_tx[1]))
    else $error("Display lane b word not on lane 2");

  AST_USB_A_ONE_LANE: assert property (
    $onehot0({lane_route[0] == HSM_SEL_USB, lane_route[1] == HSM_SEL_USB, lane_route[2] == HSM_SEL_USB}))
    else $error("USB controller a granted on more than one lane");

  AST_USB_B_LANE3: assert property (
    lane_route[3] == HSM_SEL_USB |-> usb_rx[1] == $past(lane_rx[3]) && lane_tx[3] == $past(usb_tx[1]))
    else $error("USB controller b not joined to lane 3");

  AST_SGMII_SAME_LANE: assert property (
    lane_route[2] == HSM_SEL_SGMII |-> sgmii_rx[2] == $past(lane_rx[2]) && lane_tx[2] == $past(sgmii_tx[2]))
    else $error("SGMII port 2 not joined to lane 2");

  AST_IDLE_LANE_QUIET: assert property (
    !$past(rst) && $past(lane_sel[1]) == HSM_SEL_IDLE |-> lane_route[1] == HSM_SEL_IDLE && lane_tx[1] == '0)
    else $error("Idle lane 1 is not quiet");

  AST_STORAGE_A_LANE0: assert property (
    lane_route[0] == HSM_SEL_STORAGE |-> storage_rx[0] == $past(lane_rx[0]) && lane_tx[0] == $past(storage_tx[0]))
    else $error("Storage channel a not joined to lane 0");

  AST_STORAGE_B_ONCE: assert property (
    !(lane_route[1] == HSM_SEL_STORAGE && lane_route[3] == HSM_SEL_STORAGE))
    else $error("Storage channel b granted on two lanes");

  AST_DISPLAY_A_LANE1: assert property (
    lane_route[1] == HSM_SEL_DISPLAY |-> lane_tx[1] == $past(display_tx[0]))
    else $error("Display lane a word not on lane 1");

  AST_DISPLAY_B_ONCE: assert property (
    !(lane_route[0] == HSM_SEL_DISPLAY && lane_route[2] == HSM_SEL_DISPLAY))
    else $error("Display lane b granted on two lanes");

  AST_USB_A_LANE0: assert property (
    lane_route[0] == HSM_SEL_USB |-> usb_rx[0] == $past(lane_rx[0]) && lane_tx[0] == $past(usb_tx[0]))
    else $error("USB controller a not joined to lane 0");

  AST_USB_B_ONLY_LANE3: assert property (
    lane_route[3] != HSM_SEL_USB |-> usb_rx[1] == '0)
    else $error("USB controller b receives without lane 3");

  AST_SGMII_LANE0: assert property (
    lane_route[0] == HSM_SEL_SGMII |-> sgmii_rx[0] == $past(lane_rx[0]) && lane_tx[0] == $past(sgmii_tx[0]))
    else $error("SGMII port 0 not joined to lane 0");

  AST_SGMII_RX3_UNROUTED: assert property (
    lane_route[3] != HSM_SEL_SGMII |-> sgmii_rx[3] == '0)
    else $error("SGMII port 3 receives without lane 3");

  AST_PCIE_RX0_UNROUTED: assert property (
    lane_route[0] != HSM_SEL_PCIE |-> pcie_rx[0] == '0)
    else $error("PCIe lane 0 receives while not routed");

  // Conflict policy: the lower lane keeps a shared peripheral
  AST_CONFLICT_LOWER_WINS: assert property (
    !$past(rst) && $past(lane_sel[0]) == HSM_SEL_STORAGE && $past(lane_sel[2]) == HSM_SEL_STORAGE
      |-> lane_route[2] == HSM_SEL_IDLE && lane_tx[2] == '0)
    else $error("Storage conflict did not idle lane 2");

  COV_PCIE_X4: cover property (
    lane_route == {4{HSM_SEL_PCIE}});

  COV_STORAGE_BOTH: cover property (
    lane_route[2] == HSM_SEL_STORAGE && lane_route[3] == HSM_SEL_STORAGE);

  COV_USB_BOTH: cover property (
    lane_route[0] == HSM_SEL_USB && lane_route[3] == HSM_SEL_USB);

  COV_CONFLICT_IDLED: cover property (
    lane_sel[0] == HSM_SEL_DISPLAY && lane_sel[2] == HSM_SEL_DISPLAY ##1 lane_route[2] == HSM_SEL_IDLE);

  COV_MIXED_CLASSES: cover property (
    lane_route[0] == HSM_SEL_USB && lane_route[1] == HSM_SEL_STORAGE && lane_route[2] == HSM_SEL_DISPLAY
      && lane_route[3] == HSM_SEL_SGMII);

endmodule

//--- inc/hsm_pkg.sv
// Shared types and constants for the high-speed lane multiplexer
package hsm_pkg;

  // Transceiver lane count and parallel word width
  localparam int HSM_NUM_LANES = 4;
  localparam int HSM_WORD_W = 20;
  localparam int HSM_NUM_STORAGE = 2;
  localparam int HSM_NUM_DISPLAY = 2;
  localparam int HSM_NUM_USB = 2;

  // Lane 3 is the only home of the second USB controller
  localparam int HSM_USB_B_LANE = 3;

  // Peripheral class requested for a lane; idle must stay first (reset code)
  typedef enum logic [2:0] {
    HSM_SEL_IDLE,
    HSM_SEL_PCIE,
    HSM_SEL_STORAGE,
    HSM_SEL_DISPLAY,
    HSM_SEL_USB,
    HSM_SEL_SGMII
  } hsm_sel_e;

  // One parallel word crossing a lane in either direction
  typedef struct packed {
    logic [HSM_WORD_W-1:0] data;
    logic valid;
  } hsm_word_s;

  localparam hsm_word_s HSM_WORD_IDLE = '0;

  // Whole registered state of the multiplexer
  typedef struct packed {
    hsm_sel_e [HSM_NUM_LANES-1:0] route;
    hsm_word_s [HSM_NUM_LANES-1:0] lane_tx;
    hsm_word_s [HSM_NUM_LANES-1:0] pcie_rx;
    hsm_word_s [HSM_NUM_STORAGE-1:0] storage_rx;
    hsm_word_s [HSM_NUM_USB-1:0] usb_rx;
    hsm_word_s [HSM_NUM_LANES-1:0] sgmii_rx;
  } hsm_state_s;

  localparam hsm_state_s HSM_STATE_RST = '0;

endpackage

//--- src/hsm_lane_sel.sv
// Transmit selector for one transceiver lane
`timescale 1ns/1ps
module hsm_lane_sel (
  // Granted route of this lane
  input wire hsm_pkg::hsm_sel_e route,
  // Candidate words of the peripherals wired to this lane
  input wire hsm_pkg::hsm_word_s pcie_tx,
  input wire hsm_pkg::hsm_word_s storage_tx,
  input wire hsm_pkg::hsm_word_s display_tx,
  input wire hsm_pkg::hsm_word_s usb_tx,
  input wire hsm_pkg::hsm_word_s sgmii_tx,
  // Word toward the lane
  output hsm_pkg::hsm_word_s lane_tx
);
  import hsm_pkg::*;

  always_comb begin
    case (route)
      HSM_SEL_PCIE: lane_tx = pcie_tx;
      HSM_SEL_STORAGE: lane_tx = storage_tx;
      HSM_SEL_DISPLAY: lane_tx = display_tx;
      HSM_SEL_USB: lane_tx = usb_tx;
      HSM_SEL_SGMII: lane_tx = sgmii_tx;
      default: lane_tx = HSM_WORD_IDLE;
    endcase
  end

endmodule

//--- bench/hsm_far_model.sv
// Far-side model: peripheral controllers and lane receivers
`timescale 1ns/1ps
module hsm_far_model (
  // Clock
  input wire logic sys_clk,
  // Words toward the multiplexer
  output hsm_pkg::hsm_word_s [3:0] lane_rx,
  output hsm_pkg::hsm_word_s [3:0] pcie_tx,
  output hsm_pkg::hsm_word_s [3:0] sgmii_tx,
  output hsm_pkg::hsm_word_s [1:0] storage_tx,
  output hsm_pkg::hsm_word_s [1:0] display_tx,
  output hsm_pkg::hsm_word_s [1:0] usb_tx
);
  import hsm_pkg::*;
  logic [11:0] cnt_reg = 12'h000;
  // Fresh word each cycle, so a stale or swapped path shows
  always @(negedge sys_clk) cnt_reg <= cnt_reg + 12'h001;
  for (genvar i = 0; i < 4; i++) begin : g_src
    assign lane_rx[i] = {4'h1, 4'(i), cnt_reg, 1'b1};
    assign pcie_tx[i] = {4'h2, 4'(i), cnt_reg, 1'b1};
    assign sgmii_tx[i] = {4'h3, 4'(i), cnt_reg, 1'b1};
    if (i < 2) begin : g_pair
      assign storage_tx[i] = {4'h4, 4'(i), cnt_reg, 1'b1};
      assign display_tx[i] = {4'h5, 4'(i), cnt_reg, 1'b1};
      assign usb_tx[i] = {4'h6, 4'(i), cnt_reg, 1'b1};
    end
  end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the high-speed lane multiplexer
`timescale 1ns/1ps
module testbench;
  import hsm_pkg::*;
  typedef hsm_sel_e [3:0] hsm_route_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  hsm_route_t lane_sel = hsm_route_t'({4{HSM_SEL_PCIE}});
  hsm_route_t lane_route;
  hsm_word_s [3:0] lane_rx, lane_tx, pcie_tx, pcie_rx, sgmii_tx, sgmii_rx;
  hsm_word_s [1:0] storage_tx, storage_rx, display_tx, usb_tx, usb_rx;
  int error_cnt = 0;
  int samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  hsm_lane_mux i_dut (.sys_clk(sys_clk), .rst(rst), .lane_sel(lane_sel), .lane_route(lane_route),
    .lane_rx(lane_rx), .lane_tx(lane_tx), .pcie_tx(pcie_tx), .pcie_rx(pcie_rx), .storage_tx(storage_tx),
    .storage_rx(storage_rx), .display_tx(display_tx), .usb_tx(usb_tx), .usb_rx(usb_rx),
    .sgmii_tx(sgmii_tx), .sgmii_rx(sgmii_rx));
  hsm_far_model i_far (.sys_clk(sys_clk), .lane_rx(lane_rx), .pcie_tx(pcie_tx), .sgmii_tx(sgmii_tx),
    .storage_tx(storage_tx), .display_tx(display_tx), .usb_tx(usb_tx));
  task automatic cmp_val(input string name, input logic [20:0] exp, input logic [20:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Outputs are sampled 1 ns after the edge; the model only moves at the falling edge
  task automatic apply(input logic [11:0] sel, input logic [11:0] exp_raw);
    hsm_route_t exp;
    hsm_word_s [3:0] e_tx, e_pcie, e_sgmii;
    hsm_word_s [1:0] e_st, e_usb;
    exp = hsm_route_t'(exp_raw);
    e_tx = '0;
    e_pcie = '0;
    e_sgmii = '0;
    e_st = '0;
    e_usb = '0;
    @(negedge sys_clk);
    lane_sel = hsm_route_t'(sel);
    @(posedge sys_clk);
    #1;
    for (int l = 0; l < 4; l++) begin
      case (exp[l])
        HSM_SEL_PCIE: begin e_tx[l] = pcie_tx[l]; e_pcie[l] = lane_rx[l]; end
        HSM_SEL_SGMII: begin e_tx[l] = sgmii_tx[l]; e_sgmii[l] = lane_rx[l]; end
        HSM_SEL_STORAGE: begin e_tx[l] = storage_tx[l%2]; e_st[l%2] = lane_rx[l]; end
        HSM_SEL_DISPLAY: e_tx[l] = display_tx[1-l%2];
        HSM_SEL_USB: begin e_tx[l] = usb_tx[l/3]; e_usb[l/3] = lane_rx[l]; end
        default: e_tx[l] = HSM_WORD_IDLE;
      endcase
    end
    for (int l = 0; l < 4; l++) begin
      cmp_val("lane_route", 21'(exp[l]), 21'(lane_route[l]));
      cmp_val("lane_tx", e_tx[l], lane_tx[l]);
      cmp_val("pcie_rx", e_pcie[l], pcie_rx[l]);
      cmp_val("sgmii_rx", e_sgmii[l], sgmii_rx[l]);
      if (l < 2) cmp_val("storage_rx", e_st[l], storage_rx[l]);
      if (l < 2) cmp_val("usb_rx", e_usb[l], usb_rx[l]);
    end
  endtask
  task automatic t_reset();
    repeat (3) @(posedge sys_clk);
    #1;
    for (int l = 0; l < 4; l++) cmp_val("reset lane_tx", HSM_WORD_IDLE, lane_tx[l]);
    cmp_val("reset route", 21'h0, 21'(lane_route));
    @(negedge sys_clk);
    rst = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_pcie_sgmii();
    apply({4{HSM_SEL_PCIE}}, {4{HSM_SEL_PCIE}});
    apply({4{HSM_SEL_SGMII}}, {4{HSM_SEL_SGMII}});
    $display("test pcie sgmii done");
  endtask
  // Reset in mid-run must drop live routes and then let traffic resume
  task automatic t_reset_mid();
    @(negedge sys_clk);
    rst = 1'b1;
    @(posedge sys_clk);
    #1;
    for (int l = 0; l < 4; l++) begin
      cmp_val("mid reset lane_tx", HSM_WORD_IDLE, lane_tx[l]);
      cmp_val("mid reset pcie_rx", HSM_WORD_IDLE, pcie_rx[l]);
      cmp_val("mid reset sgmii_rx", HSM_WORD_IDLE, sgmii_rx[l]);
    end
    cmp_val("mid reset route", 21'h0, 21'(lane_route));
    @(negedge sys_clk);
    rst = 1'b0;
    apply({4{HSM_SEL_PCIE}}, {4{HSM_SEL_PCIE}});
    $display("test mid reset done");
  endtask
  task automatic t_storage_display();
    apply({{4{HSM_SEL_STORAGE}}}, {{2{HSM_SEL_IDLE}}, {2{HSM_SEL_STORAGE}}});
    apply({{2{HSM_SEL_STORAGE}}, {2{HSM_SEL_IDLE}}}, {{2{HSM_SEL_STORAGE}}, {2{HSM_SEL_IDLE}}});
    apply({4{HSM_SEL_DISPLAY}}, {{2{HSM_SEL_IDLE}}, {2{HSM_SEL_DISPLAY}}});
    apply({{2{HSM_SEL_DISPLAY}}, {2{HSM_SEL_IDLE}}}, {{2{HSM_SEL_DISPLAY}}, {2{HSM_SEL_IDLE}}});
    $display("test storage display done");
  endtask
  task automatic t_usb_mixed();
    apply({4{HSM_SEL_USB}}, {HSM_SEL_USB, {2{HSM_SEL_IDLE}}, HSM_SEL_USB});
    apply({HSM_SEL_USB, HSM_SEL_USB, {2{HSM_SEL_IDLE}}}, {HSM_SEL_USB, HSM_SEL_USB, {2{HSM_SEL_IDLE}}});
    apply({HSM_SEL_SGMII, HSM_SEL_DISPLAY, HSM_SEL_STORAGE, HSM_SEL_USB},
      {HSM_SEL_SGMII, HSM_SEL_DISPLAY, HSM_SEL_STORAGE, HSM_SEL_USB});
    apply({3'h7, 3'h6, 3'h7, 3'h6}, {4{HSM_SEL_IDLE}});
    $display("test usb mixed done");
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    t_reset();
    t_pcie_sgmii();
    t_reset_mid();
    t_storage_display();
    t_usb_mixed();
    give_verdict();
  end
  // Hang guard
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule
